/* File: design/rbm_top.sv */
// Reset, boot-mode, memory-mode and access control of the processor.
`timescale 1ns/1ps
module rbm_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic mode_a,
  input wire logic mode_b,
  input wire logic programmable_flag_two,
  input wire logic mode_d,
  input wire logic bus_request,
  input wire logic boot_word_done,
  input wire logic host_pm0_write,
  input wire logic host_ack_req,
  input wire logic [1:0] program_overlay_select,
  input wire logic [13:0] pm_addr,
  input wire logic ext_data_req,
  input wire logic [2:0] data_wait_states,
  input wire logic wait_mode,
  output logic core_run,
  output logic [13:0] fetch_addr,
  output logic fetch_external,
  output logic byte_memory_dma_boot,
  output logic host_port_dma_boot,
  output logic host_mode,
  output logic [15:0] mode_status_register,
  output logic [3:0] stack_ptr,
  output logic [9:0] int_mask,
  output logic host_access_ack_out,
  output logic host_access_ack_oe_n,
  output logic [13:0] ext_addr,
  output logic ovl_reserved,
  output logic data_wait
);
  rbm_pkg::rbm_state_t state, next_state;
  logic released;
  logic [2:0] strap;
  logic strap_d;
  logic [4:0] boot_cnt;
  logic wait_busy;

  // Straps are caught by a clocked process on the first enabled edge after release, so the
  // asynchronous reset itself only loads constants.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      released <= 1'b0;
      strap <= 3'h0;
      strap_d <= 1'b0;
    end else if (clk_en && !released) begin
      released <= 1'b1;
      strap <= {programmable_flag_two, mode_b, mode_a};
      strap_d <= mode_d;
    end
  end

  wire is_byte_boot = (strap == rbm_pkg::MODE_BYTE_FULL) || (strap == rbm_pkg::MODE_BYTE_HOST);
  wire is_host_boot = (strap == rbm_pkg::MODE_PORT_HOST);
  wire is_noboot = (strap == rbm_pkg::MODE_NOBOOT);
  wire strap_host = strap[2];
  wire boot_last = (boot_cnt == rbm_pkg::BOOT_WORDS);

  always_comb begin
    next_state = state;
    case (state)
      rbm_pkg::RBM_IDLE: begin
        if (released && !bus_request) begin
          if (is_byte_boot) begin
            next_state = rbm_pkg::RBM_BYTE_BOOT;
          end else if (is_host_boot) begin
            next_state = rbm_pkg::RBM_HOST_BOOT;
          end else if (is_noboot) begin
            next_state = rbm_pkg::RBM_RUN;
          end else begin
            next_state = rbm_pkg::RBM_HALT;
          end
        end
      end
      rbm_pkg::RBM_BYTE_BOOT: begin
        if (boot_word_done && boot_last) begin
          next_state = rbm_pkg::RBM_RUN;
        end
      end
      rbm_pkg::RBM_HOST_BOOT: begin
        if (host_pm0_write) begin
          next_state = rbm_pkg::RBM_RUN;
        end
      end
      rbm_pkg::RBM_RUN: next_state = rbm_pkg::RBM_RUN;
      rbm_pkg::RBM_HALT: next_state = rbm_pkg::RBM_HALT;
      default: next_state = rbm_pkg::RBM_IDLE;
    endcase
  end

  // Reset is purely asynchronous and never waits for a stabilization count.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rbm_pkg::RBM_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt <= 5'h00;
    end else if (clk_en && state == rbm_pkg::RBM_BYTE_BOOT && boot_word_done) begin
      boot_cnt <= boot_cnt + 5'h01;
    end
  end

  wire next_run = (next_state == rbm_pkg::RBM_RUN);
  // Only the no-boot mode starts from external memory; host mode never executes externally.
  wire next_ext = next_run && is_noboot && !strap_host;
  wire host_now = released && strap_host;
  wire ovl_ok = (program_overlay_select == rbm_pkg::OVL_ONE) ||
                (program_overlay_select == rbm_pkg::OVL_TWO);
  wire [13:0] low_addr = pm_addr - rbm_pkg::OVL_BASE;
  wire [13:0] full_addr = {program_overlay_select == rbm_pkg::OVL_TWO, low_addr[12:0]};
  wire [13:0] next_ext_addr = host_now ? {13'h0000, pm_addr[0]} : full_addr;
  wire ack_od = host_now && strap_d;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_run <= 1'b0;
      fetch_addr <= rbm_pkg::START_ADDR;
      fetch_external <= 1'b0;
      byte_memory_dma_boot <= 1'b0;
      host_port_dma_boot <= 1'b0;
      host_mode <= 1'b0;
      mode_status_register <= rbm_pkg::MODE_STATUS_RESET;
      stack_ptr <= rbm_pkg::STACK_EMPTY;
      int_mask <= rbm_pkg::IMASK_RESET;
      host_access_ack_out <= 1'b0;
      host_access_ack_oe_n <= 1'b1;
      ext_addr <= 14'h0000;
      ovl_reserved <= 1'b0;
      data_wait <= 1'b0;
    end else if (clk_en) begin
      core_run <= next_run;
      fetch_addr <= rbm_pkg::START_ADDR;
      fetch_external <= next_ext;
      byte_memory_dma_boot <= (next_state == rbm_pkg::RBM_BYTE_BOOT);
      host_port_dma_boot <= (next_state == rbm_pkg::RBM_HOST_BOOT);
      host_mode <= host_now;
      // The board pull-down gives the low level, so open drain only ever drives high.
      // That is what lets several acknowledge pins share one wired-OR line.
      host_access_ack_out <= ack_od ? 1'b1 : host_ack_req;
      host_access_ack_oe_n <= !(host_now && (!strap_d || host_ack_req));
      ext_addr <= next_ext_addr;
      ovl_reserved <= !ovl_ok && !host_now;
      data_wait <= wait_busy || (ext_data_req && !wait_busy);
    end
  end

  rbm_wait_gen u_wait (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(ext_data_req),
    .data_wait_states(data_wait_states),
    .wait_mode(wait_mode),
    .busy(wait_busy)
  );

  property p_hold_boot;
    @(posedge ref_clk) disable iff (!rst_n)
      byte_memory_dma_boot |-> !core_run;
  endproperty
  a_hold_boot: assert property (p_hold_boot) else $error("ran during boot");

  property p_bus_req;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_IDLE && bus_request) |=> state == rbm_pkg::RBM_IDLE;
  endproperty
  a_bus_req: assert property (p_bus_req) else $error("boot despite bus request");

  property p_strap_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      released |=> $stable(strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_host_pm0;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_HOST_BOOT && host_pm0_write) |=> core_run;
  endproperty
  a_host_pm0: assert property (p_host_pm0) else $error("no run after pm0 write");

  property p_od;
    @(posedge ref_clk) disable iff (!rst_n)
      (host_mode && strap_d && !host_access_ack_oe_n) |-> host_access_ack_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove low");

  property p_active;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && host_now && !strap_d) |=> !host_access_ack_oe_n;
  endproperty
  a_active: assert property (p_active) else $error("ack not driven");

  property p_host_addr;
    @(posedge ref_clk) disable iff (!rst_n)
      host_mode |-> ext_addr[13:1] == 13'h0000;
  endproperty
  a_host_addr: assert property (p_host_addr) else $error("host addr wide");

  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(core_run) |-> fetch_addr == rbm_pkg::START_ADDR && !byte_memory_dma_boot &&
        !host_port_dma_boot;
  endproperty
  a_start: assert property (p_start) else $error("bad start address");

  property p_reset_vals;
    @(posedge ref_clk) disable iff (!rst_n)
      mode_status_register == rbm_pkg::MODE_STATUS_RESET &&
        stack_ptr == rbm_pkg::STACK_EMPTY && int_mask == rbm_pkg::IMASK_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset state lost");

  property p_strap_take;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !released) |=> strap[2] == $past(programmable_flag_two) &&
        strap[1] == $past(mode_b) && strap[0] == $past(mode_a);
  endproperty
  a_strap_take: assert property (p_strap_take) else $error("strap not taken");

  property p_byte_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_IDLE && released && !bus_request && is_byte_boot)
        |=> byte_memory_dma_boot && !core_run;
  endproperty
  a_byte_start: assert property (p_byte_start) else $error("byte boot not started");

  property p_halt;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_IDLE && released && !bus_request && !is_byte_boot &&
        !is_host_boot && !is_noboot) |=> state == rbm_pkg::RBM_HALT && !core_run;
  endproperty
  a_halt: assert property (p_halt) else $error("bad mode ran");

  property p_noboot_run;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_IDLE && released && !bus_request && is_noboot)
        |=> core_run && fetch_external;
  endproperty
  a_noboot_run: assert property (p_noboot_run) else $error("no-boot start wrong");

  property p_byte_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_BYTE_BOOT && !(boot_word_done && boot_last))
        |=> byte_memory_dma_boot && !core_run;
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("boot ended early");

  property p_byte_done;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_BYTE_BOOT && boot_word_done && boot_last)
        |=> core_run && !byte_memory_dma_boot;
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("boot did not end");

  property p_host_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state == rbm_pkg::RBM_HOST_BOOT && !host_pm0_write)
        |=> host_port_dma_boot && !core_run;
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host boot ended early");

  property p_od_release;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && host_now && strap_d && !host_ack_req) |=> host_access_ack_oe_n;
  endproperty
  a_od_release: assert property (p_od_release) else $error("open drain not released");

  property p_no_ext_host;
    @(posedge ref_clk) disable iff (!rst_n)
      host_mode |-> !fetch_external;
  endproperty
  a_no_ext_host: assert property (p_no_ext_host) else $error("host mode ran external");

  property p_ovl_one;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !host_now && program_overlay_select == rbm_pkg::OVL_ONE)
        |=> !ext_addr[rbm_pkg::OVL_BIT] && !ovl_reserved;
  endproperty
  a_ovl_one: assert property (p_ovl_one) else $error("overlay one wrong");

  property p_ovl_two;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !host_now && program_overlay_select == rbm_pkg::OVL_TWO)
        |=> ext_addr[rbm_pkg::OVL_BIT] && !ovl_reserved;
  endproperty
  a_ovl_two: assert property (p_ovl_two) else $error("overlay two wrong");

  property p_ovl_res;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !host_now && !ovl_ok) |=> ovl_reserved;
  endproperty
  a_ovl_res: assert property (p_ovl_res) else $error("reserved overlay not flagged");

  property p_data_stall;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && ext_data_req && !wait_busy) |=> data_wait;
  endproperty
  a_data_stall: assert property (p_data_stall) else $error("external access not held");

  property p_internal;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !ext_data_req && !wait_busy) |=> !data_wait;
  endproperty
  a_internal: assert property (p_internal) else $error("internal access stalled");
endmodule

/* File: design/rbm_pkg.sv */
// Constants shared by the reset and boot-mode control block.
// How it works
// - Low reset forces a complete master reset of all internal state.
// - A later reset never waits for clock stabilization; clock keeps running.
// - Master reset empties stack pointers, masks interrupts, clears mode status.
// - Boot runs after release only with no bus request and a booting mode.
// - After boot the first fetch is from on-chip program address zero.
// - Memory mode strap is read at reset release; pin becomes a flag afterwards.
// - Mode 000: byte DMA loads 32 words, hold, full memory mode.
// - Mode 010: no boot, start at external address 0, full memory mode.
// - Mode 100: byte DMA loads 32 words, hold, host mode.
// - Mode 101: host mode, host DMA loads, hold until program address 0 written.
// - Host mode with D=0 drives the acknowledge actively.
// - Host mode with D=1 drives the acknowledge open drain, board pulls down.
// - Full mode program memory is 24 bits, 8K on chip plus two overlays.
// - Overlay select 1 gives bit 13 low, 2 gives high; 0 and 3 are reserved.
// - Host mode overlays use address line zero only; no external execution.
// - Data memory 16 bits, 8K on chip, internal accesses take one cycle.
// - External data accesses stretch by the data wait-state count and mode; the code stalls one cycle longer than the count.
package rbm_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PLL_LOCK_CYCLES = 2000;
  localparam logic [4:0] BOOT_WORDS = 5'h1F;
  localparam logic [13:0] START_ADDR = 14'h0000;
  localparam logic [13:0] OVL_BASE = 14'h2000;
  localparam logic [1:0] OVL_ONE = 2'h1;
  localparam logic [1:0] OVL_TWO = 2'h2;
  localparam int unsigned OVL_BIT = 13;
  localparam int unsigned PM_WIDTH = 24;
  localparam int unsigned DM_WIDTH = 16;
  localparam logic [15:0] MODE_STATUS_RESET = 16'h0000;
  localparam logic [3:0] STACK_EMPTY = 4'h0;
  localparam logic [9:0] IMASK_RESET = 10'h000;
  localparam logic [2:0] MODE_BYTE_FULL = 3'h0;
  localparam logic [2:0] MODE_NOBOOT = 3'h2;
  localparam logic [2:0] MODE_BYTE_HOST = 3'h4;
  localparam logic [2:0] MODE_PORT_HOST = 3'h5;
  typedef enum logic [2:0] {
    RBM_IDLE, RBM_BYTE_BOOT, RBM_HOST_BOOT, RBM_RUN, RBM_HALT
  } rbm_state_t;
endpackage

/* File: design/rbm_wait_gen.sv */
// Wait-state stretcher for external data memory accesses.
`timescale 1ns/1ps
module rbm_wait_gen (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [2:0] data_wait_states,
  input wire logic wait_mode,
  output logic busy
);
  logic [3:0] cnt;
  // Mode bit doubles the count and adds one, reaching up to 15 waits.
  wire [3:0] load_val = wait_mode ? {data_wait_states, 1'b1} : {1'b0, data_wait_states};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
    end else if (clk_en) begin
      if (start && cnt == 4'h0) begin
        cnt <= load_val;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  assign busy = (cnt != 4'h0);
  property p_wait_count;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && start && !busy) |=> cnt == $past(load_val);
  endproperty
  a_wait_count: assert property (p_wait_count) else $error("wait count wrong");

  property p_wait_step;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && busy) |=> cnt == $past(cnt) - 4'h1;
  endproperty
  a_wait_step: assert property (p_wait_step) else $error("wait step wrong");
endmodule

/* File: verif/rbm_board.sv */
// Board model: mode C strap pin and the byte-memory or host boot source.
`timescale 1ns/1ps
module rbm_board (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic strap_c,
  input wire logic byte_memory_dma_boot,
  input wire logic host_port_dma_boot,
  output logic programmable_flag_two,
  output logic boot_word_done,
  output logic host_pm0_write,
  output int words
);
  int held;
  // The strap driver lets go after capture; the pin then toggles as a busy flag would.
  assign programmable_flag_two = (!rst_n || held < 2) ? strap_c : held[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 0;
      words <= 0;
      boot_word_done <= 1'b0;
      host_pm0_write <= 1'b0;
    end else begin
      held <= held + 1;
      // Words come in back-to-back pairs with gaps, so both spacings are exercised.
      boot_word_done <= byte_memory_dma_boot && held[1];
      host_pm0_write <= host_port_dma_boot && held == 20;
      if ((boot_word_done && byte_memory_dma_boot) || (host_pm0_write && host_port_dma_boot)) begin
        words <= words + 1;
      end
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the reset and boot-mode control block.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, mode_a = 1'b0, mode_b = 1'b0, strap_c = 1'b0;
  logic mode_d = 1'b0, bus_request = 1'b0, host_ack_req = 1'b0, ext_data_req = 1'b0;
  logic wait_mode = 1'b0, programmable_flag_two, boot_word_done, host_pm0_write;
  logic clk_en = 1'b1;
  logic [1:0] program_overlay_select = 2'h0;
  logic [13:0] pm_addr = 14'h0000;
  logic [2:0] data_wait_states = 3'h0;
  logic core_run, fetch_external, byte_memory_dma_boot, host_port_dma_boot, host_mode;
  logic host_access_ack_out, host_access_ack_oe_n, ovl_reserved, data_wait;
  logic [13:0] fetch_addr, ext_addr;
  logic [15:0] mode_status_register;
  logic [3:0] stack_ptr;
  logic [9:0] int_mask;
  logic [31:0] seed = 32'h0000094A;
  logic [3:0] modes [11] = '{4'h0, 4'h8, 4'h2, 4'h4, 4'hC, 4'h5, 4'hD, 4'h1, 4'h3, 4'h6, 4'h7};
  int words, failures = 0, checks_done = 0;
  always #2 ref_clk = ~ref_clk;
  rbm_top rbm_top_i (.ref_clk, .rst_n, .clk_en, .mode_a, .mode_b, .programmable_flag_two,
    .mode_d, .bus_request, .boot_word_done, .host_pm0_write, .host_ack_req,
    .program_overlay_select, .pm_addr, .ext_data_req, .data_wait_states, .wait_mode, .core_run,
    .fetch_addr, .fetch_external, .byte_memory_dma_boot, .host_port_dma_boot, .host_mode,
    .mode_status_register, .stack_ptr, .int_mask, .host_access_ack_out, .host_access_ack_oe_n,
    .ext_addr, .ovl_reserved, .data_wait);
  rbm_board rbm_board_i (.ref_clk, .rst_n, .strap_c, .byte_memory_dma_boot, .host_port_dma_boot,
    .programmable_flag_two, .boot_word_done, .host_pm0_write, .words);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run_mode(input logic [3:0] m, input logic breq);
    int n;
    logic [2:0] cba;
    logic [1:0] boot_seen;
    logic exp_run;
    logic [31:0] r;
    logic [3:0] w;
    logic [15:0] frozen;
    cba = m[2:0];
    boot_seen = 2'h0;
    exp_run = !breq && (cba == 3'h0 || cba == 3'h2 || cba == 3'h4 || cba == 3'h5);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    {mode_d, strap_c, mode_b, mode_a} <= m;
    bus_request <= breq;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(mode_status_register, rbm_pkg::MODE_STATUS_RESET);
    chk(16'(stack_ptr), 16'(rbm_pkg::STACK_EMPTY));
    chk(16'(int_mask), 16'(rbm_pkg::IMASK_RESET));
    chk({core_run, host_access_ack_oe_n}, 16'h0001);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    n = 0;
    while (!core_run && n < 200) begin
      @(negedge ref_clk);
      n++;
      if (n == 3) boot_seen = {byte_memory_dma_boot, host_port_dma_boot};
    end
    chk(16'(core_run), 16'(exp_run));
    chk(16'(host_mode), 16'(cba[2]));
    chk(16'(boot_seen), exp_run ? {14'h0, cba == 3'h0 || cba == 3'h4, cba == 3'h5} : 16'h0);
    if (exp_run) begin
      chk(16'(words), cba == 3'h5 ? 16'h1 : (cba == 3'h2 ? 16'h0 : 16'h20));
      chk(16'(fetch_addr), 16'(rbm_pkg::START_ADDR));
      chk({fetch_external, byte_memory_dma_boot, host_port_dma_boot}, {cba == 3'h2, 2'h0});
      for (int i = 0; i < 8; i++) begin
        r = rnd();
        @(posedge ref_clk);
        host_ack_req <= r[0];
        program_overlay_select <= r[2:1];
        pm_addr <= r[16:3];
        repeat (2) @(negedge ref_clk);
        // With the board pull-down, a released pin reads low.
        if (cba[2] && m[3]) chk({host_access_ack_oe_n, !host_access_ack_oe_n && host_access_ack_out},
          {!r[0], r[0]});
        if (cba[2] && !m[3]) chk({host_access_ack_out, host_access_ack_oe_n}, {r[0], 1'b0});
        if (cba[2]) chk(16'(ext_addr[0]), 16'(r[3]));
        if (!cba[2]) chk(16'(ovl_reserved), 16'(r[2:1] == 2'h0 || r[2:1] == 2'h3));
        if (!cba[2] && r[2] != r[1]) chk(16'(ext_addr), {2'h0, r[2], r[15:3]});
      end
      frozen = {host_access_ack_out, host_access_ack_oe_n, ext_addr};
      @(posedge ref_clk);
      clk_en <= 1'b0;
      host_ack_req <= !host_ack_req;
      pm_addr <= ~pm_addr;
      repeat (2) @(negedge ref_clk);
      chk({host_access_ack_out, host_access_ack_oe_n, ext_addr}, frozen);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      r = rnd();
      w = r[3] ? {r[2:0], 1'b1} : {1'b0, r[2:0]};
      @(posedge ref_clk);
      data_wait_states <= r[2:0];
      wait_mode <= r[3];
      ext_data_req <= 1'b1;
      @(posedge ref_clk);
      ext_data_req <= 1'b0;
      n = 0;
      repeat (24) begin
        @(negedge ref_clk);
        n += data_wait;
      end
      // The request cycle itself is held as well, so the stall is one longer than the count.
      chk(16'(n), 16'(w) + 16'h1);
    end
    $display("mode %h request %0d done, checks %0d", m, breq, checks_done);
  endtask
  initial begin
    repeat (rbm_pkg::PLL_LOCK_CYCLES) @(posedge ref_clk);
    foreach (modes[i]) run_mode(modes[i], 1'b0);
    run_mode(4'h0, 1'b1);
    complete_run();
  end
  initial begin
    #80000;
    failures++;
    complete_run();
  end
endmodule
